// ===== rtl/vci_slave.sv
// VME slave with multicast write, chained readout and release-on-access interrupter
`timescale 1ns/1ps
module vci_slave #(
    parameter int CNT_W = 6
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // VME inputs
    input wire logic [31:1] vme_addr_i,
    input wire logic [5:0] vme_am_i,
    input wire logic vme_as_n_i,
    input wire logic vme_ds0_n_i,
    input wire logic vme_ds1_n_i,
    input wire logic vme_write_n_i,
    input wire logic vme_lword_n_i,
    input wire logic vme_iack_n_i,
    input wire logic vme_iackin_n_i,
    input wire logic [31:0] vme_data_i,
    // VME outputs
    output logic [31:0] vme_data_o,
    output logic vme_data_oe_n_o,
    output logic vme_dtack_n_o,
    output logic vme_berr_n_o,
    output logic vme_iackout_n_o,
    output logic [7:1] vme_irq_n_o,
    // Board side
    input wire logic base_hit_i,
    input wire logic [CNT_W-1:0] evt_count_i,
    input wire logic [31:0] obuf_data_i,
    input wire logic obuf_tag_i,
    input wire logic obuf_empty_i,
    output logic obuf_rd_o
);

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    localparam int SW = 76;
    localparam logic [SW-1:0] SYNC_RST = {7'h7F, 69'h0};

    logic [SW-1:0] raw_w;
    logic [SW-1:0] sync_w;
    logic as_s, ds_s, wr_s, lw_s, iack_s, iackin_s;
    logic [31:1] addr_s;
    logic [5:0] am_s;
    logic [31:0] dat_s;

    assign raw_w = {vme_as_n_i, vme_ds0_n_i, vme_ds1_n_i, vme_write_n_i, vme_lword_n_i,
                    vme_iack_n_i, vme_iackin_n_i, vme_addr_i, vme_am_i, vme_data_i};

    vci_sync #(.W(SW), .RST(SYNC_RST)) u_sync (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .d_i(raw_w),
        .q_o(sync_w)
    );

    assign as_s = ~sync_w[75];
    assign ds_s = ~(sync_w[74] & sync_w[73]);
    assign wr_s = ~sync_w[72];
    assign lw_s = ~sync_w[71];
    assign iack_s = ~sync_w[70];
    assign iackin_s = ~sync_w[69];
    assign addr_s = sync_w[68:38];
    assign am_s = sync_w[37:32];
    assign dat_s = sync_w[31:0];

    // ************************************************************
    // Decoding
    // ************************************************************
    function automatic vci_pkg::vci_am_kind_t am_kind(input logic [5:0] am);
        if (am == vci_pkg::AM_CBLT_SUP || am == vci_pkg::AM_CBLT_USR) begin
            return vci_pkg::VCI_AM_CBLT;
        end else if (am == vci_pkg::AM_MCST_SUP || am == vci_pkg::AM_MCST_USR) begin
            return vci_pkg::VCI_AM_MCST;
        end else begin
            return vci_pkg::VCI_AM_OTHER;
        end
    endfunction

    function automatic logic reg_known(input logic [15:0] ofs);
        return ofs == vci_pkg::OFS_GEO || ofs == vci_pkg::OFS_CBASE ||
               ofs == vci_pkg::OFS_IRQ_LEVEL || ofs == vci_pkg::OFS_IRQ_VECTOR ||
               ofs == vci_pkg::OFS_CHAIN_CTRL || ofs == vci_pkg::OFS_EVT_TRIG;
    endfunction

    vci_pkg::vci_state_t st_q;
    vci_pkg::vci_am_kind_t kind_w;
    logic [7:0] cbase_q;
    logic [4:0] geo_q;
    logic [2:0] lvl_q;
    logic [7:0] vec_q;
    logic [15:0] trig_q;
    logic [1:0] ctrl_q;
    logic [15:0] ofs_w;
    logic chain_hit_w, chain_on_w, obuf_sel_w, is_first_w, is_last_w;
    logic mcst_ok_w, cblt_ok_w, base_reg_w, reg_wr_w, idle_cyc_w;

    assign ofs_w = {addr_s[15:1], 1'b0};
    assign kind_w = am_kind(am_s);
    assign chain_hit_w = (addr_s[vci_pkg::CHAIN_SEL_MSB:vci_pkg::CHAIN_SEL_LSB] == cbase_q) &&
                         (addr_s[vci_pkg::CHAIN_ZERO_MSB:vci_pkg::CHAIN_ZERO_LSB] == 8'h00);
    assign chain_on_w = ctrl_q != vci_pkg::POS_INACTIVE;
    assign is_first_w = ctrl_q == vci_pkg::POS_FIRST;
    assign is_last_w = ctrl_q == vci_pkg::POS_LAST;
    assign obuf_sel_w = ofs_w < vci_pkg::OBUF_LIMIT;
    assign idle_cyc_w = st_q == vci_pkg::ST_IDLE && as_s && ds_s && !iack_s;

    // Other chains' addresses miss here, so boards stay silent
    assign mcst_ok_w = chain_hit_w && chain_on_w && kind_w == vci_pkg::VCI_AM_MCST &&
                       wr_s && !lw_s && reg_known(ofs_w);
    assign cblt_ok_w = chain_hit_w && chain_on_w && kind_w == vci_pkg::VCI_AM_CBLT &&
                       !wr_s && lw_s && obuf_sel_w;
    assign base_reg_w = base_hit_i && !lw_s && reg_known(ofs_w);
    // Every active board stores a multicast write at once
    assign reg_wr_w = idle_cyc_w && wr_s && (mcst_ok_w || base_reg_w);

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            cbase_q <= vci_pkg::CBASE_RST;
            geo_q <= vci_pkg::GEO_RST;
            lvl_q <= vci_pkg::IRQ_LEVEL_RST;
            vec_q <= vci_pkg::IRQ_VECTOR_RST;
            trig_q <= vci_pkg::EVT_TRIG_RST;
            ctrl_q <= vci_pkg::CHAIN_CTRL_RST;
        end else if (reg_wr_w) begin
            if (ofs_w == vci_pkg::OFS_GEO) begin
                geo_q <= dat_s[4:0];
            end else if (ofs_w == vci_pkg::OFS_CBASE) begin
                cbase_q <= dat_s[7:0];
            end else if (ofs_w == vci_pkg::OFS_IRQ_LEVEL) begin
                lvl_q <= dat_s[2:0];
            end else if (ofs_w == vci_pkg::OFS_IRQ_VECTOR) begin
                vec_q <= dat_s[7:0];
            end else if (ofs_w == vci_pkg::OFS_CHAIN_CTRL) begin
                ctrl_q <= dat_s[1:0];
            end else if (ofs_w == vci_pkg::OFS_EVT_TRIG) begin
                trig_q <= dat_s[15:0];
            end
        end
    end

    logic [15:0] rd_mux_w;

    always_comb begin
        if (ofs_w == vci_pkg::OFS_GEO) begin
            rd_mux_w = {11'h000, geo_q};
        end else if (ofs_w == vci_pkg::OFS_CBASE) begin
            rd_mux_w = {8'h00, cbase_q};
        end else if (ofs_w == vci_pkg::OFS_IRQ_LEVEL) begin
            rd_mux_w = {13'h0000, lvl_q};
        end else if (ofs_w == vci_pkg::OFS_IRQ_VECTOR) begin
            rd_mux_w = {8'h00, vec_q};
        end else if (ofs_w == vci_pkg::OFS_CHAIN_CTRL) begin
            rd_mux_w = {14'h0000, ctrl_q};
        end else begin
            rd_mux_w = trig_q;
        end
    end

    // ************************************************************
    // Interrupter
    // ************************************************************
    logic irq_q;
    logic [15:0] cnt_ext_w;

    assign cnt_ext_w = 16'(evt_count_i);

    // Release on access: draining the buffer below the trigger, or a zero level or trigger, drops the request
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            irq_q <= 1'b0;
        end else if (lvl_q == 3'h0 || trig_q == 16'h0000) begin
            irq_q <= 1'b0;
        end else if (cnt_ext_w == trig_q) begin
            irq_q <= 1'b1;
        end else if (cnt_ext_w < trig_q) begin
            irq_q <= 1'b0;
        end
    end

    for (genvar i = 1; i <= 7; i++) begin : g_irq
        assign vme_irq_n_o[i] = ~(irq_q && lvl_q == 3'(i));
    end

    // ************************************************************
    // Bus cycle machine
    // ************************************************************
    logic dtack_q, berr_q, oe_q, iackout_q, rd_q;
    logic burst_q, chain_q, token_q, iackcyc_q;
    logic [31:0] data_q;
    logic [5:0] cyc_am_q;
    logic [31:0] obuf_word_w;

    // Slot id replaces the top bits of tagged words
    assign obuf_word_w = obuf_tag_i ? {geo_q, obuf_data_i[vci_pkg::GEO_LSB-1:0]} : obuf_data_i;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st_q <= vci_pkg::ST_IDLE;
            dtack_q <= 1'b0;
            berr_q <= 1'b0;
            oe_q <= 1'b0;
            iackout_q <= 1'b0;
            rd_q <= 1'b0;
            burst_q <= 1'b0;
            chain_q <= 1'b0;
            token_q <= 1'b0;
            iackcyc_q <= 1'b0;
            data_q <= 32'h0000_0000;
            cyc_am_q <= 6'h00;
        end else begin
            rd_q <= 1'b0;
            case (st_q)
                vci_pkg::ST_IDLE: begin
                    burst_q <= 1'b0;
                    chain_q <= 1'b0;
                    token_q <= 1'b0;
                    iackcyc_q <= 1'b0;
                    if (as_s && iack_s && iackin_s) begin
                        iackcyc_q <= 1'b1;
                        if (!(irq_q && addr_s[3:1] == lvl_q)) begin
                            iackout_q <= 1'b1;
                            st_q <= vci_pkg::ST_PASS;
                        end else if (ds_s) begin
                            data_q <= {24'h00_0000, vec_q};
                            oe_q <= 1'b1;
                            dtack_q <= 1'b1;
                            st_q <= vci_pkg::ST_BEAT_END;
                        end
                    end else if (idle_cyc_w) begin
                        cyc_am_q <= am_s;
                        if (mcst_ok_w || cblt_ok_w) begin
                            chain_q <= 1'b1;
                            burst_q <= cblt_ok_w;
                            st_q <= vci_pkg::ST_TOKEN_WAIT;
                        end else if (base_reg_w) begin
                            data_q <= wr_s ? 32'h0000_0000 : {16'h0000, rd_mux_w};
                            oe_q <= !wr_s;
                            dtack_q <= 1'b1;
                            st_q <= vci_pkg::ST_BEAT_END;
                        end else if (base_hit_i && lw_s && !wr_s && obuf_sel_w) begin
                            burst_q <= 1'b1;
                            st_q <= vci_pkg::ST_BEAT_WAIT;
                        end else begin
                            // Unsupported access: no answer, master times out
                            st_q <= vci_pkg::ST_END_WAIT;
                        end
                    end
                end
                vci_pkg::ST_TOKEN_WAIT: begin
                    if (!as_s) begin
                        st_q <= vci_pkg::ST_IDLE;
                    end else if (is_first_w || iackin_s) begin
                        token_q <= 1'b1;
                        if (burst_q) begin
                            st_q <= vci_pkg::ST_BEAT_WAIT;
                        end else if (is_last_w) begin
                            dtack_q <= 1'b1;
                            st_q <= vci_pkg::ST_BEAT_END;
                        end else begin
                            iackout_q <= 1'b1;
                            st_q <= vci_pkg::ST_PASS;
                        end
                    end
                end
                vci_pkg::ST_BEAT_WAIT: begin
                    if (!as_s) begin
                        st_q <= vci_pkg::ST_IDLE;
                    end else if (ds_s) begin
                        if (!obuf_empty_i) begin
                            data_q <= obuf_word_w;
                            rd_q <= 1'b1;
                            oe_q <= 1'b1;
                            dtack_q <= 1'b1;
                            st_q <= vci_pkg::ST_BEAT_END;
                        end else if (!chain_q || is_last_w) begin
                            // Last board ends the chained readout
                            berr_q <= 1'b1;
                            st_q <= vci_pkg::ST_BEAT_END;
                        end else begin
                            iackout_q <= 1'b1;
                            st_q <= vci_pkg::ST_PASS;
                        end
                    end
                end
                vci_pkg::ST_BEAT_END: begin
                    if (!ds_s) begin
                        dtack_q <= 1'b0;
                        berr_q <= 1'b0;
                        oe_q <= 1'b0;
                        st_q <= (burst_q && !berr_q) ? vci_pkg::ST_BEAT_WAIT : vci_pkg::ST_END_WAIT;
                    end
                end
                vci_pkg::ST_PASS: begin
                    if (!as_s) begin
                        iackout_q <= 1'b0;
                        st_q <= vci_pkg::ST_IDLE;
                    end
                end
                default: begin
                    if (!as_s) begin
                        st_q <= vci_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign vme_data_o = data_q;
    assign vme_data_oe_n_o = ~oe_q;
    assign vme_dtack_n_o = ~dtack_q;
    assign vme_berr_n_o = ~berr_q;
    assign vme_iackout_n_o = ~iackout_q;
    assign obuf_rd_o = rd_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);

    chk_cblt_am_code: assert property (
        (rd_q && chain_q) |-> (cyc_am_q == vci_pkg::AM_CBLT_SUP || cyc_am_q == vci_pkg::AM_CBLT_USR))
        else $error("chained read under wrong modifier");
    chk_mcst_am_code: assert property (
        (reg_wr_w && !base_reg_w) |-> (am_s == vci_pkg::AM_MCST_SUP || am_s == vci_pkg::AM_MCST_USR))
        else $error("multicast write under wrong modifier");
    chk_mcst_no_read: assert property (
        (chain_q && !burst_q) |-> !oe_q)
        else $error("multicast cycle drove data");
    chk_cblt_read_only: assert property (
        $rose(chain_q && burst_q) |-> $past(!wr_s && lw_s && obuf_sel_w))
        else $error("chained burst not a buffer read");
    chk_cbase_reset: assert property (
        $fell(srst_i) |-> cbase_q == vci_pkg::CBASE_RST)
        else $error("chain address reset value wrong");
    chk_chain_decode: assert property (
        $rose(chain_q) |-> $past(addr_s[vci_pkg::CHAIN_ZERO_MSB:vci_pkg::CHAIN_ZERO_LSB] == 8'h00))
        else $error("chain hit with nonzero middle byte");
    chk_token_data: assert property (
        (chain_q && (oe_q || dtack_q)) |-> token_q)
        else $error("data moved without token");
    chk_berr_last: assert property (
        (berr_q && chain_q) |-> ctrl_q == vci_pkg::POS_LAST)
        else $error("chain end signalled by non-last board");
    chk_geo_tag: assert property (
        (rd_q && $past(obuf_tag_i)) |-> data_q[vci_pkg::GEO_MSB:vci_pkg::GEO_LSB] == geo_q)
        else $error("tag word lacks slot id");
    chk_iack_vector: assert property (
        (iackcyc_q && dtack_q) |-> (oe_q && data_q[7:0] == vec_q && data_q[31:8] == 24'h00_0000))
        else $error("acknowledge id wrong");
    chk_irq_enable: assert property (
        (vme_irq_n_o != 7'h7F) |-> (lvl_q != 3'h0 && trig_q != 16'h0000))
        else $error("request while disabled");
    chk_irq_hold: assert property (
        (irq_q && cnt_ext_w >= trig_q && lvl_q != 3'h0 && trig_q != 16'h0000) |=> irq_q)
        else $error("request dropped early");
    chk_reg_d16: assert property (
        ($rose(dtack_q) && !burst_q && !iackcyc_q) |-> $past(!lw_s))
        else $error("register cycle not 16 bit");
    chk_iack_pass: assert property (
        $rose(iackout_q && iackcyc_q) |-> $past(!(irq_q && addr_s[3:1] == lvl_q)))
        else $error("matching acknowledge passed on");

    cov_mcst_write: cover property (reg_wr_w && mcst_ok_w);
    cov_cblt_beat: cover property (rd_q && chain_q);
    cov_iack_reply: cover property (iackcyc_q && dtack_q);
    cov_token_pass: cover property ($rose(iackout_q) && chain_q);
    cov_chain_end: cover property (berr_q && chain_q);

endmodule

// ===== common/vci_pkg.sv
// Shared constants and types for the chained-access VME slave
package vci_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [15:0] OFS_GEO = 16'h1002;
    localparam logic [15:0] OFS_CBASE = 16'h1004;
    localparam logic [15:0] OFS_IRQ_LEVEL = 16'h100A;
    localparam logic [15:0] OFS_IRQ_VECTOR = 16'h100C;
    localparam logic [15:0] OFS_CHAIN_CTRL = 16'h101A;
    localparam logic [15:0] OFS_EVT_TRIG = 16'h1020;
    localparam logic [15:0] OBUF_LIMIT = 16'h0800;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] CBASE_RST = 8'hAA;
    localparam logic [4:0] GEO_RST = 5'h00;
    localparam logic [2:0] IRQ_LEVEL_RST = 3'h0;
    localparam logic [7:0] IRQ_VECTOR_RST = 8'h00;
    localparam logic [15:0] EVT_TRIG_RST = 16'h0000;
    localparam logic [1:0] CHAIN_CTRL_RST = 2'h0;

    // ************************************************************
    // Address modifiers and field layout
    // ************************************************************
    localparam logic [5:0] AM_CBLT_SUP = 6'h0F;
    localparam logic [5:0] AM_CBLT_USR = 6'h0B;
    localparam logic [5:0] AM_MCST_SUP = 6'h0D;
    localparam logic [5:0] AM_MCST_USR = 6'h09;
    localparam int CHAIN_SEL_MSB = 31;
    localparam int CHAIN_SEL_LSB = 24;
    localparam int CHAIN_ZERO_MSB = 23;
    localparam int CHAIN_ZERO_LSB = 16;
    localparam int GEO_MSB = 31;
    localparam int GEO_LSB = 27;
    localparam logic [1:0] POS_INACTIVE = 2'h0;
    localparam logic [1:0] POS_LAST = 2'h1;
    localparam logic [1:0] POS_FIRST = 2'h2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum {VCI_AM_OTHER, VCI_AM_MCST, VCI_AM_CBLT} vci_am_kind_t;
    typedef enum {ST_IDLE, ST_TOKEN_WAIT, ST_BEAT_WAIT, ST_BEAT_END, ST_PASS, ST_END_WAIT} vci_state_t;

endpackage

// ===== rtl/vci_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin inputs
`timescale 1ns/1ps
module vci_sync #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta_q;

    // First stage feeds the second stage only
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            meta_q <= RST;
            q_o <= RST;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end

endmodule

// ===== verif/vci_mst.sv
// Bus master model driving the slave's VME pins
`timescale 1ns/1ps
module vci_mst (
    // Clock
    input wire logic ref_clk_i,
    // Slave answer
    input wire logic dtack_n_i,
    input wire logic berr_n_i,
    input wire logic [31:0] data_i,
    // Pins driven
    output logic [31:1] addr_o,
    output logic [5:0] am_o,
    output logic as_n_o,
    output logic ds_n_o,
    output logic [2:0] mode_o,
    output logic [31:0] data_o
);
    logic [31:0] rq[$];
    logic [1:0] sq[$];
    int n;
    initial {addr_o, am_o, as_n_o, ds_n_o, mode_o, data_o} = '1;
    // Mode is write_n, lword_n, iack_n; a released bus shows inverted data
    task automatic cyc(input logic [31:0] a, input logic [5:0] m, input logic [2:0] f, input logic [31:0] d,
                       input int nb);
        @(posedge ref_clk_i);
        {addr_o, am_o, mode_o, as_n_o} <= {a[31:1], m, f, 1'b0};
        data_o <= f[2] ? ~data_o : d;
        repeat (nb) begin
            @(posedge ref_clk_i);
            ds_n_o <= 1'b0;
            n = 0;
            do begin @(posedge ref_clk_i); n++; end while (dtack_n_i & berr_n_i & n < 12);
            rq.push_back(data_i);
            sq.push_back(n < 12 ? {1'b0, dtack_n_i} : 2'h2);
            ds_n_o <= 1'b1;
            do @(posedge ref_clk_i); while (!(dtack_n_i & berr_n_i));
        end
        as_n_o <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
    endtask
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the chained-access VME slave
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ikin_n = 1'b1;
    logic [5:0] evt = 6'h00;
    logic [32:0] ob[4] = '{default: 33'h0};
    logic [1:0] hd = 2'h0;
    logic [1:0] tl = 2'h0;
    logic [31:0] md, sd, lf, d, bus;
    logic [31:1] a;
    logic [5:0] am;
    logic [2:0] mo, lv;
    logic as_n, ds_n, oe_n, dt_n, be_n, io_n, rd;
    logic [7:1] irq_n;
    logic [7:0] c;
    logic [4:0] g;
    int fail_count = 0;
    int cmp_count = 0;
    int ps = 0;
    int p0;
    assign bus = oe_n ? md : sd;
    always #25 clk = ~clk;
    always @(posedge clk) begin
        if (rd === 1'b1) hd <= hd + 2'h1;
        if (io_n === 1'b0) ps <= ps + 1;
    end
    vci_slave u_dut (
        .ref_clk_i(clk), .srst_i(srst), .vme_addr_i(a), .vme_am_i(am), .vme_as_n_i(as_n),
        .vme_ds0_n_i(ds_n), .vme_ds1_n_i(ds_n), .vme_write_n_i(mo[2]), .vme_lword_n_i(mo[1]),
        .vme_iack_n_i(mo[0]), .vme_iackin_n_i(ikin_n), .vme_data_i(bus), .vme_data_o(sd),
        .vme_data_oe_n_o(oe_n), .vme_dtack_n_o(dt_n), .vme_berr_n_o(be_n), .vme_iackout_n_o(io_n),
        .vme_irq_n_o(irq_n), .base_hit_i(a[31:16] == 16'h1234), .evt_count_i(evt),
        .obuf_data_i(ob[hd][31:0]), .obuf_tag_i(ob[hd][32]), .obuf_empty_i(hd == tl), .obuf_rd_o(rd)
    );
    vci_mst u_mst (
        .ref_clk_i(clk), .dtack_n_i(dt_n), .berr_n_i(be_n), .data_i(bus), .addr_o(a), .am_o(am),
        .as_n_o(as_n), .ds_n_o(ds_n), .mode_o(mo), .data_o(md)
    );
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Tagged words carry the slot id in the top five bits
    function automatic logic [31:0] ew(input logic [32:0] w, input logic [4:0] id);
        return w[32] ? {id, w[26:0]} : w[31:0];
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic acc(input logic [31:0] ad, input logic [5:0] m, input logic [2:0] f, input logic [31:0] wd,
                       input logic [1:0] er, input logic [31:0] ed);
        u_mst.cyc(ad, m, f, wd, 1);
        chk("resp", {30'h0, er}, {30'h0, u_mst.sq.pop_front()});
        d = u_mst.rq.pop_front();
        if (f[2] && er == 2'h0) chk("data", ed, d);
    endtask
    task automatic wr(input logic [15:0] o, input logic [31:0] v);
        acc({16'h1234, o}, 6'h09, 3'h3, v, 2'h0, 0);
    endtask
    task automatic rr(input logic [15:0] o, input logic [31:0] e);
        acc({16'h1234, o}, 6'h09, 3'h7, 0, 2'h0, e);
    endtask
    task automatic iq(input logic [5:0] n, input logic on);
        evt <= n;
        repeat (4) @(posedge clk);
        chk("irq", {25'h0, ~(7'(on) << (lv - 3'h1))}, {25'h0, irq_n});
    endtask
    task automatic report_and_stop;
        if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        lf = 32'h4A4FEA43;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rr(16'h1004, 32'hAA);
        rr(16'h101A, 0);
        rr(16'h1020, 0);
        acc(32'h12341000, 6'h09, 3'h7, 0, 2'h2, 0);
        acc(32'h1234100C, 6'h09, 3'h5, 0, 2'h2, 0);
        lf = nx(lf);
        c = lf[7:0] | 8'h80;
        g = lf[12:8];
        wr(16'h1004, {24'h0, c});
        wr(16'h1002, {27'h0, g});
        wr(16'h101A, 1);
        ikin_n <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            lf = nx(lf);
            acc({c, 8'h00, 16'h1020}, i ? 6'h09 : 6'h0D, 3'h3, {26'h0, lf[5:0]}, 2'h0, 0);
            rr(16'h1020, {26'h0, lf[5:0]});
        end
        for (int i = 0; i < 3; i++)
            acc({c ^ 8'(i == 1), 8'(i == 2), 16'h1020}, i ? 6'h0D : 6'h39, 3'h3, ~lf, 2'h2, 0);
        acc({c, 8'h00, 16'h1020}, 6'h0D, 3'h7, 0, 2'h2, 0);
        rr(16'h1020, {26'h0, lf[5:0]});
        for (int i = 0; i < 2; i++) begin
            lf = nx(lf);
            ob[hd] <= {1'b1, lf};
            ob[hd + 2'h1] <= {1'b0, ~lf};
            tl <= hd + 2'h2;
            u_mst.cyc({c, 24'h0}, i ? 6'h0B : 6'h0F, 3'h5, 0, 3);
            for (int k = 0; k < 3; k++) begin
                chk("resp", k / 2, {30'h0, u_mst.sq.pop_front()});
                d = u_mst.rq.pop_front();
                if (k < 2) chk("data", k ? ew({1'b0, ~lf}, g) : ew({1'b1, lf}, g), d);
            end
        end
        acc({c, 24'h0}, 6'h0F, 3'h7, 0, 2'h2, 0);
        // Plain buffer read at the board base: one word, then empty ends it
        lf = nx(lf);
        ob[hd] <= {1'b1, lf};
        tl <= hd + 2'h1;
        acc(32'h12340000, 6'h09, 3'h5, 0, 2'h0, ew({1'b1, lf}, g));
        acc(32'h12340000, 6'h09, 3'h5, 0, 2'h1, 0);
        wr(16'h101A, 2);
        p0 = ps;
        acc({c, 24'h0}, 6'h0F, 3'h5, 0, 2'h2, 0);
        chk("pass", 32'h1, {31'h0, ps > p0});
        lf = nx(lf);
        lv = lf[2:0] == 3'h0 ? 3'h3 : lf[2:0];
        wr(16'h100A, {29'h0, lv});
        wr(16'h100C, {24'h0, lf[15:8]});
        wr(16'h1020, 5);
        iq(6'h04, 1'b0);
        iq(6'h05, 1'b1);
        acc({28'h0, lv, 1'b0}, 6'h09, 3'h6, 0, 2'h0, lf[15:8]);
        acc({28'h0, lv, 1'b0}, 6'h09, 3'h4, 0, 2'h0, lf[15:8]);
        p0 = ps;
        acc({28'h0, lv ^ 3'h4, 1'b0}, 6'h09, 3'h6, 0, 2'h2, 0);
        chk("pass", 32'h1, {31'h0, ps > p0});
        iq(6'h06, 1'b1);
        iq(6'h04, 1'b0);
        wr(16'h100A, 0);
        iq(6'h05, 1'b0);
        report_and_stop;
    end
    initial begin
        #250000;
        fail_count++;
        report_and_stop;
    end
endmodule
